// ### rtl/fcr_sequencer.sv
// camera-side timing generator that reads one full frame from the sensor
// How it works
// RULE1: sensor has 3088 columns of 2056 elements; the row count follows that
// RULE2: 3072x2048 active area plus 16 dark columns and 8 dark rows
// RULE3: each row transfer moves one row into the 3100-stage horizontal register
// RULE4: both vertical phases stay low for the whole exposure
// RULE5: read by vertical row transfer first, then horizontal shift-out
// RULE6: row loads on falling vertical_phase_b while horizontal_phase_a is high
// RULE7: horizontal phases toggle alternately and always complementary
// RULE8: each falling horizontal_phase_b puts one packet on the diffusion node
// RULE9: reset gate pulses only after the video sample strobe
// RULE10: rows carry 6 leading and 10 trailing dark pixels after dummies
// RULE11: frame starts and ends with 4 dark rows
// RULE12: edge-adjacent dark pixels and first two rows are not true dark
// RULE13: register has 10 leading and 2 trailing dummy stages
// RULE14: first few leading dummies are flagged as possibly false
// RULE15: reset gate toggles every pixel throughout readout; here it pulses only after each sample, none in a row's first pixel period
// RULE16: one frame is 2056 row transfers each followed by a shift-out
// RULE17: each vertical phase pulse lasts at least 10 us
// RULE18: pixel period is at least 67 ns
// RULE19: all 3100 shifts finish before the next row transfer
`timescale 1ns/1ps
`include "fcr_consts.svh"

module fcr_sequencer
  import fcr_pkg::*;
#(
  parameter int unsigned V_PULSE_CYC   = `FCR_V_PULSE_CYC,
  parameter int unsigned HALF_PIX_CYC  = `FCR_HALF_PIX_CYC,
  parameter int unsigned H_SETUP_CYC   = `FCR_H_SETUP_CYC,
  parameter int unsigned ROWS          = `FCR_ROWS,
  parameter int unsigned HREG_LEN      = `FCR_HREG_LEN
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        start_exposure,
  input  wire logic        end_exposure,
  output logic             vertical_phase_a,
  output logic             vertical_phase_b,
  output logic             horizontal_phase_a,
  output logic             horizontal_phase_b,
  output logic             reset_gate,
  output logic             sample_strobe,
  output logic [11:0]      pixel_col,
  output logic [11:0]      pixel_row,
  output logic [2:0]       pixel_kind,
  output logic             busy,
  output logic             frame_done
);

  fcr_state_type state_reg;
  logic [15:0]   timer_reg;
  logic [11:0]   row_reg;
  logic [11:0]   col_reg;
  logic          phase_reg;   // 0: first half of pixel (H1 high), 1: second half

  wire timer_done = (timer_reg == 16'h0000);
  // the count after the last stage shifts nothing; it only lets that stage be sampled
  // before its reset, so a line takes one pixel period more than the register length
  wire last_col   = (col_reg == 12'(HREG_LEN)); // RULE9 RULE19
  wire last_row   = (row_reg == 12'(ROWS - 1));

  // main sequencer: exposure, vertical transfer, horizontal shift-out
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FCR_IDLE;
      timer_reg <= 16'h0000;
      row_reg   <= 12'h000;
      col_reg   <= 12'h000;
      phase_reg <= 1'b0;
    end else begin
      case (state_reg)
        FCR_IDLE: begin
          if (start_exposure) begin
            state_reg <= FCR_INTEG;
          end
        end
        FCR_INTEG: begin
          row_reg <= 12'h000;
          if (end_exposure) begin
            state_reg <= FCR_VA_HI; // RULE5
            timer_reg <= 16'(V_PULSE_CYC - 1);
          end
        end
        FCR_VA_HI: begin
          if (timer_done) begin
            state_reg <= FCR_VB_HI;
            timer_reg <= 16'(V_PULSE_CYC - 1); // RULE17
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        FCR_VB_HI: begin
          if (timer_done) begin
            state_reg <= FCR_VB_LO; // RULE6
            timer_reg <= 16'(V_PULSE_CYC - 1);
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        FCR_VB_LO: begin
          if (timer_done) begin
            state_reg <= FCR_HSETUP;
            timer_reg <= 16'(H_SETUP_CYC - 1);
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        FCR_HSETUP: begin
          col_reg   <= 12'h000;
          phase_reg <= 1'b0;
          if (timer_done) begin
            state_reg <= FCR_SHIFT;
            timer_reg <= 16'(HALF_PIX_CYC - 1);
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        FCR_SHIFT: begin
          if (!timer_done) begin
            timer_reg <= timer_reg - 16'h0001;
          end else begin
            timer_reg <= 16'(HALF_PIX_CYC - 1); // RULE18
            phase_reg <= ~phase_reg;
            if (phase_reg) begin
              // leave only after the flush count, when every stage has been sampled
              if (last_col) begin // RULE19
                if (last_row) begin // RULE16 RULE1
                  state_reg <= FCR_IDLE;
                end else begin
                  row_reg   <= row_reg + 12'h001;
                  state_reg <= FCR_VA_HI; // RULE3
                  timer_reg <= 16'(V_PULSE_CYC - 1);
                end
              end else begin
                col_reg <= col_reg + 12'h001;
              end
            end
          end
        end
        default: state_reg <= FCR_IDLE;
      endcase
    end
  end

  // pin drivers; vertical phases low outside transfer, H1 high around the V2 fall
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vertical_phase_a   <= 1'b0;
      vertical_phase_b   <= 1'b0;
      horizontal_phase_a <= 1'b1;
      horizontal_phase_b <= 1'b0;
    end else begin
      vertical_phase_a   <= (state_reg == FCR_VA_HI); // RULE4
      vertical_phase_b   <= (state_reg == FCR_VB_HI); // RULE4
      // the flush count keeps H1 high and H2 low, so no packet moves in it
      horizontal_phase_a <= (state_reg != FCR_SHIFT) || !phase_reg || last_col; // RULE6 RULE7
      horizontal_phase_b <= (state_reg == FCR_SHIFT) && phase_reg && !last_col; // RULE7 RULE8
    end
  end

  // sample at the end of the first half, when the packet of the previous stage sits on
  // the node, then reset one cycle later; the last stage of a row is handled the same
  // way, so no packet is ever cleared unsampled
  // reset follows each sample strobe only, so none comes in the first pixel period of a row or during row transfer
  wire pix_end = (state_reg == FCR_SHIFT) && phase_reg && timer_done;
  wire sample_now = (state_reg == FCR_SHIFT) && !phase_reg && timer_done && (col_reg != 12'h000);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_strobe <= 1'b0;
      reset_gate    <= 1'b0;
    end else begin
      sample_strobe <= sample_now;
      reset_gate    <= sample_strobe; // RULE9 RULE15
    end
  end

  // classify the pixel being sampled (previous column reaches the node)
  // geometry follows the module parameters, so a shortened register still ends in
  // its trailing dummies; a frame shorter than eight rows holds dark rows only
  logic [11:0] smp_col;
  logic [2:0]  kind_next;
  assign smp_col = col_reg - 12'h001;
  always_comb begin
    if (smp_col < 12'(`FCR_DUMMY_LEAD)) begin // RULE13
      kind_next = (smp_col < 12'(`FCR_FALSE_DUMMIES)) ? FCR_PIX_DUMMY_BAD : FCR_PIX_DUMMY; // RULE14
    end else if (smp_col >= 12'(HREG_LEN - `FCR_DUMMY_TRAIL)) begin
      kind_next = FCR_PIX_DUMMY;
    end else if (row_reg < 12'(`FCR_DARK_ROWS) ||
                 row_reg >= 12'(ROWS - `FCR_DARK_ROWS)) begin // RULE11 RULE2
      kind_next = (row_reg < 12'(`FCR_EDGE_ROWS) || row_reg == 12'(`FCR_DARK_ROWS - 1) ||
                   row_reg == 12'(ROWS - `FCR_DARK_ROWS)) ? FCR_PIX_DARK : FCR_PIX_DARK_REF; // RULE12
    end else if (smp_col < 12'(`FCR_DUMMY_LEAD + `FCR_DARK_LEAD)) begin // RULE10
      kind_next = (smp_col == 12'(`FCR_DUMMY_LEAD + `FCR_DARK_LEAD - 1) ||
                   smp_col == 12'(`FCR_DUMMY_LEAD)) ? FCR_PIX_DARK : FCR_PIX_DARK_REF; // RULE12
    end else if (smp_col >= 12'(HREG_LEN - `FCR_DUMMY_TRAIL - `FCR_DARK_TRAIL)) begin // RULE10
      kind_next = (smp_col == 12'(HREG_LEN - `FCR_DUMMY_TRAIL - `FCR_DARK_TRAIL)) ?
                  FCR_PIX_DARK : FCR_PIX_DARK_REF;
    end else begin
      kind_next = FCR_PIX_ACTIVE;
    end
  end

  // sample tags and status, registered so outputs come from flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pixel_col  <= 12'h000;
      pixel_row  <= 12'h000;
      pixel_kind <= 3'b000;
      busy       <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      if (sample_now) begin
        pixel_col  <= smp_col;
        pixel_row  <= row_reg;
        pixel_kind <= kind_next;
      end
      busy       <= (state_reg != FCR_IDLE);
      frame_done <= pix_end && last_col && last_row;
    end
  end

endmodule

// ### rtl/fcr_consts.svh
// timing and geometry constants for the full-frame sensor readout sequencer
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH

`define FCR_CLK_PERIOD_PS    8000
`define FCR_V_PULSE_MIN_NS   10000
`define FCR_V_PULSE_CYC      ((`FCR_V_PULSE_MIN_NS * 1000 + `FCR_CLK_PERIOD_PS - 1) / `FCR_CLK_PERIOD_PS)
`define FCR_PIXEL_MIN_NS     67
`define FCR_HALF_PIX_CYC     (((`FCR_PIXEL_MIN_NS * 1000 + `FCR_CLK_PERIOD_PS - 1) / `FCR_CLK_PERIOD_PS + 1) / 2)
`define FCR_H_SETUP_NS       500
`define FCR_H_SETUP_CYC      ((`FCR_H_SETUP_NS * 1000 + `FCR_CLK_PERIOD_PS - 1) / `FCR_CLK_PERIOD_PS)
`define FCR_ROWS             2056
`define FCR_COLS             3088
`define FCR_HREG_LEN         3100
`define FCR_DUMMY_LEAD       10
`define FCR_DUMMY_TRAIL      2
`define FCR_DARK_LEAD        6
`define FCR_DARK_TRAIL       10
`define FCR_DARK_ROWS        4
`define FCR_EDGE_ROWS        2
`define FCR_FALSE_DUMMIES    3

`endif

// ### rtl/fcr_pkg.sv
// types for the full-frame sensor readout sequencer
package fcr_pkg;
  typedef enum logic [2:0] {
    FCR_IDLE   = 3'b000,
    FCR_INTEG  = 3'b001,
    FCR_VA_HI  = 3'b010,
    FCR_VB_HI  = 3'b011,
    FCR_VB_LO  = 3'b100,
    FCR_HSETUP = 3'b101,
    FCR_SHIFT  = 3'b110
  } fcr_state_type;

  typedef enum logic [2:0] {
    FCR_PIX_DUMMY     = 3'b000,
    FCR_PIX_DARK      = 3'b001,
    FCR_PIX_DARK_REF  = 3'b010,
    FCR_PIX_ACTIVE    = 3'b011,
    FCR_PIX_DUMMY_BAD = 3'b100
  } fcr_pix_type;
endpackage

// ### testbench/fcr_readout_monitor.sv
// concurrent checks on the sequencer's sensor-side pins
`timescale 1ns/1ps
module fcr_readout_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic vertical_phase_a,
  input wire logic vertical_phase_b,
  input wire logic horizontal_phase_a,
  input wire logic horizontal_phase_b,
  input wire logic reset_gate,
  input wire logic sample_strobe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // widths of 4 hold only for the bench's shortened vertical pulse
  a_h_complement: assert property (horizontal_phase_b |-> !horizontal_phase_a)
    else $error("h phases overlap");
  a_reset_after: assert property (sample_strobe |=> reset_gate)
    else $error("no reset after sample");
  a_load_with_ha: assert property ($fell(vertical_phase_b) |-> horizontal_phase_a)
    else $error("row load with h low");
  a_va_width: assert property (
    $rose(vertical_phase_a) |-> vertical_phase_a[*4] ##1 vertical_phase_b)
    else $error("first v pulse width");
  a_vb_width: assert property (
    $rose(vertical_phase_b) |-> vertical_phase_b[*4] ##1 !vertical_phase_b[*4])
    else $error("second v pulse width");
  a_v_exclusive: assert property (!(vertical_phase_a && vertical_phase_b))
    else $error("v phases overlap");
  a_quiet_rows: assert property (
    vertical_phase_a || vertical_phase_b |-> !horizontal_phase_b && !sample_strobe)
    else $error("shift during row transfer");
  a_pixel_half: assert property ($rose(horizontal_phase_b) |=> !horizontal_phase_b)
    else $error("h half period");
  a_reset_only_after: assert property (reset_gate |-> $past(sample_strobe))
    else $error("reset without sample");
  cover property ($fell(vertical_phase_b));
  cover property (sample_strobe ##1 reset_gate);
  cover property ($fell(horizontal_phase_b));
endmodule

// ### testbench/fcr_sensor_model.sv
// behavioural sensor: counts row loads and packets reaching the output node
`timescale 1ns/1ps
module fcr_sensor_model #(
  parameter int HREG_LEN = 3100
) (
  input  wire logic rst_n,
  input  wire logic vertical_phase_b,
  input  wire logic horizontal_phase_a,
  input  wire logic horizontal_phase_b,
  output int        row_loads,
  output int        packets,
  output bit        mixed
);
  int in_hreg = 0;
  // dark and dummy stages are plain stages here; only counts matter
  initial begin
    row_loads = 0;
    packets = 0;
    mixed = 1'b0;
  end
  // leftover charge at a load means two rows got mixed
  always @(negedge vertical_phase_b) if (rst_n === 1'b1) begin
    if (horizontal_phase_a !== 1'b1 || in_hreg != 0) mixed = 1'b1;
    row_loads++;
    in_hreg = HREG_LEN;
  end
  // each fall of the second phase puts one packet on the floating_diffusion_node
  always @(negedge horizontal_phase_b) if (rst_n === 1'b1) begin
    packets++;
    if (in_hreg > 0) in_hreg--;
  end
endmodule

// ### testbench/tb_top.sv
// self-checking bench: sequencer against sensor and pixel-order models
`timescale 1ns/1ps
module tb_top;
  localparam int HL = 20;
  localparam int RW = 3;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start_exposure = 1'b0;
  logic        end_exposure = 1'b0;
  logic        vertical_phase_a, vertical_phase_b, horizontal_phase_a, horizontal_phase_b;
  logic        reset_gate, sample_strobe, busy, frame_done;
  logic [11:0] pixel_col, pixel_row;
  logic [2:0]  pixel_kind;
  logic [7:0]  seed = 8'h24;
  int          fail_count = 0, checks_done = 0, cyc = 0, exp_col = 0, exp_row = 0, n;
  int          row_loads, packets;
  int          rst_pulses = 0;
  bit          mixed;
  always #4 sys_clk = ~sys_clk;
  fcr_sequencer #(.V_PULSE_CYC(4), .HALF_PIX_CYC(1), .H_SETUP_CYC(2), .ROWS(RW),
    .HREG_LEN(HL)) u_fcr_sequencer (.sys_clk(sys_clk), .rst_n(rst_n),
    .start_exposure(start_exposure), .end_exposure(end_exposure),
    .vertical_phase_a(vertical_phase_a), .vertical_phase_b(vertical_phase_b),
    .horizontal_phase_a(horizontal_phase_a), .horizontal_phase_b(horizontal_phase_b),
    .reset_gate(reset_gate), .sample_strobe(sample_strobe), .pixel_col(pixel_col),
    .pixel_row(pixel_row), .pixel_kind(pixel_kind), .busy(busy), .frame_done(frame_done));
  fcr_sensor_model #(.HREG_LEN(HL)) u_fcr_sensor_model (.rst_n(rst_n),
    .vertical_phase_b(vertical_phase_b), .horizontal_phase_a(horizontal_phase_a),
    .horizontal_phase_b(horizontal_phase_b), .row_loads(row_loads), .packets(packets),
    .mixed(mixed));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // pixel-order model: every stage of every row is sampled once, in order;
  // a three-row frame is all dark rows, and the first two of them are not true dark
  always @(posedge sys_clk) if (sample_strobe === 1'b1) begin
    check(pixel_col === 12'(exp_col) && pixel_row === 12'(exp_row), "pixel order");
    if (exp_col < 10 || exp_col >= HL - 2)
      check(pixel_kind === (exp_col < 3 ? 3'h4 : 3'h0), "dummy kind");
    else
      check(pixel_kind === (exp_row < 2 ? 3'h1 : 3'h2), "dark row kind");
    exp_col++;
    if (exp_col == HL) begin
      exp_col = 0;
      exp_row++;
    end
  end
  // reset gate pulses, one per sampled pixel
  always @(posedge sys_clk) if (reset_gate === 1'b1) rst_pulses++;
  // hang guard, far above two short frames
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk) end_exposure <= 1'b1;
    @(posedge sys_clk) end_exposure <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(busy === 1'b0 && vertical_phase_a === 1'b0, "end taken while idle");
    for (int f = 1; f <= 2; f++) begin
      start_exposure <= 1'b1;
      @(posedge sys_clk) start_exposure <= 1'b0;
      seed = lfsr(seed);
      // exposure length is random; vertical phases must stay low throughout
      repeat (int'(seed[3:0]) + 2) begin
        @(posedge sys_clk);
        check(!vertical_phase_a && !vertical_phase_b, "v moved in exposure");
      end
      end_exposure <= 1'b1;
      @(posedge sys_clk) end_exposure <= 1'b0;
      #1;
      check(vertical_phase_a === 1'b0, "v early");
      @(posedge sys_clk) #1;
      check(vertical_phase_a === 1'b1, "v late");
      n = 0;
      while (frame_done !== 1'b1 && n < 1000) begin
        @(posedge sys_clk);
        n++;
      end
      #1; // let the counting processes of this edge finish first
      check(n < 1000 && exp_row == RW && exp_col == 0, "frame length");
      check(rst_pulses == HL * RW * f, "reset pulses");
      check(row_loads == RW * f && packets == HL * RW * f && !mixed, "transfers");
      exp_row = 0;
      repeat (2) @(posedge sys_clk);
    end
    give_verdict();
  end
endmodule
bind fcr_sequencer fcr_readout_monitor u_fcr_readout_monitor (.sys_clk(sys_clk),
  .rst_n(rst_n), .vertical_phase_a(vertical_phase_a), .vertical_phase_b(vertical_phase_b),
  .horizontal_phase_a(horizontal_phase_a), .horizontal_phase_b(horizontal_phase_b),
  .reset_gate(reset_gate), .sample_strobe(sample_strobe));
